// ==== adcos_defines.svh ====
// Constants for the converter output sync and test pattern block
`ifndef ADCOS_DEFINES_SVH
`define ADCOS_DEFINES_SVH

// Serial frame: 4 address bits then 16 data bits, MSB first
`define ADCOS_FRAME_BITS      5'h14
`define ADCOS_FRAME_LAST      5'h13
`define ADCOS_ADDR_MSB        19
`define ADCOS_ADDR_LSB        16

// Register addresses
`define ADCOS_ADDR_EXT_CFG    4'h9
`define ADCOS_ADDR_FINE       4'he
`define ADCOS_ADDR_COARSE     4'hf

// Reset values
`define ADCOS_RST_EXT_CFG     16'h03ff
`define ADCOS_RST_FINE        16'h00ff
`define ADCOS_RST_COARSE      16'h007f

// Field positions
`define ADCOS_PTN_BIT         15
`define ADCOS_INV_BIT         15
`define ADCOS_COARSE_MSB      14
`define ADCOS_COARSE_LSB      10
`define ADCOS_INTER_MSB       9
`define ADCOS_INTER_LSB       7
`define ADCOS_FINE_MSB        15
`define ADCOS_FINE_LSB        8
`define ADCOS_DATA_MSB        15
`define ADCOS_DATA_LSB        0

// Delay steps and limits in picoseconds
`define ADCOS_COARSE_STEP_PS  12'h041
`define ADCOS_INTER_STEP_PS   12'h00b
`define ADCOS_FINE_MAX_PS     12'h032
`define ADCOS_MAX_DELAY_PS    12'h82c

// Restart delay after resync release, in sample clock cycles
`define ADCOS_RESTART_DEMUX0  3'h4
`define ADCOS_RESTART_OTHER   3'h3

// Test pattern words and sequences
`define ADCOS_PTN_QD          8'h01
`define ADCOS_PTN_ID          8'h02
`define ADCOS_PTN_Q           8'h03
`define ADCOS_PTN_I           8'h04
`define ADCOS_PTN_ND_Q        8'h01
`define ADCOS_PTN_ND_I        8'h02
`define ADCOS_SEQ_DEMUX_LEN   4'h5
`define ADCOS_SEQ_NODMX_LEN   4'ha
`define ADCOS_SEQ_DEMUX_MASK  10'h00a
`define ADCOS_SEQ_NODMX_MASK  10'h132

`endif

// ==== adcos_pkg.sv ====
// Types shared by the output sync and test pattern block
package adcos_pkg;

    // One output word set: four data ports and the over-range flag
    typedef struct packed {
        logic [7:0] q_delayed_port;
        logic [7:0] i_delayed_port;
        logic [7:0] q_port;
        logic [7:0] i_port;
        logic       over_range;
    } adcos_word_t;

    // Output clock restart sequencer states
    typedef enum logic [1:0] {
        ADCOS_ST_RUN  = 2'b00,
        ADCOS_ST_HOLD = 2'b01,
        ADCOS_ST_WAIT = 2'b10
    } adcos_state_t;

endpackage : adcos_pkg

// ==== adcos_pattern.sv ====
// Test pattern generator for all output ports
`timescale 1ns/1ns
`default_nettype none
`include "adcos_defines.svh"

module adcos_pattern
    import adcos_pkg::*;
(
    // Clock and reset
    input  wire logic  clock_in,
    input  wire logic  rst_in,
    // Sequencing
    input  wire logic  restart_in,
    input  wire logic  step_in,
    input  wire logic  demux_in,
    // Pattern word
    output adcos_word_t word_out
);

    logic [3:0] pos_reg;
    logic [3:0] seq_len;
    logic [9:0] seq_mask;
    logic       comp;
    logic       mode_reg;
    logic       mode_chg;

    // Low word or its complement
    function automatic logic [7:0] pick(input logic [7:0] low, input logic inv);
        pick = inv ? ~low : low;
    endfunction : pick

    // Registered mode, so a mode change and the position restart land together
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            mode_reg <= 1'b0;
        else
            mode_reg <= demux_in;
    end

    assign mode_chg = demux_in != mode_reg;
    assign seq_len  = mode_reg ? `ADCOS_SEQ_DEMUX_LEN : `ADCOS_SEQ_NODMX_LEN;
    assign seq_mask = mode_reg ? `ADCOS_SEQ_DEMUX_MASK : `ADCOS_SEQ_NODMX_MASK;
    assign comp     = seq_mask[pos_reg];

    // Position in the sequence, restarted on resync release or mode change
    always_ff @(posedge clock_in)
    begin
        if (rst_in || restart_in || mode_chg)
            pos_reg <= 4'h0;
        else if (step_in)
            pos_reg <= (pos_reg >= seq_len - 4'h1) ? 4'h0 : pos_reg + 4'h1;
    end

    // Port words; non-demux drives Q and I only, delayed ports copy them
    always_comb
    begin
        if (mode_reg)
        begin
            word_out.q_delayed_port = pick(`ADCOS_PTN_QD, comp);
            word_out.i_delayed_port = pick(`ADCOS_PTN_ID, comp);
            word_out.q_port         = pick(`ADCOS_PTN_Q, comp);
            word_out.i_port         = pick(`ADCOS_PTN_I, comp);
        end
        else
        begin
            word_out.q_delayed_port = pick(`ADCOS_PTN_ND_Q, comp);
            word_out.i_delayed_port = pick(`ADCOS_PTN_ND_I, comp);
            word_out.q_port         = pick(`ADCOS_PTN_ND_Q, comp);
            word_out.i_port         = pick(`ADCOS_PTN_ND_I, comp);
        end
        word_out.over_range = comp;
    end

    property p_pos_range;
        @(posedge clock_in) disable iff (rst_in) pos_reg < seq_len;
    endproperty
    a_pos_range: assert property (p_pos_range) else $error("pattern position out of range");

    property p_restart_zero;
        @(posedge clock_in) disable iff (rst_in) restart_in |=> pos_reg == 4'h0 && !comp;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("pattern not restarted");

    property p_demux_alt;
        @(posedge clock_in) disable iff (rst_in)
            mode_reg && !mode_chg && step_in && !restart_in && pos_reg == 4'h0
            ##1 mode_reg |-> comp;
    endproperty
    a_demux_alt: assert property (p_demux_alt) else $error("demux sequence wrong");

endmodule : adcos_pattern
`default_nettype wire

// ==== adcos_output_sync.sv ====
// Output clock sync, phase registers and test pattern output of a dual converter
`timescale 1ns/1ns
`default_nettype none
`include "adcos_defines.svh"

module adcos_output_sync
    import adcos_pkg::*;
(
    // Sample clock domain
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // Serial register port, on its own clock
    input  wire logic        serial_clock_in,
    input  wire logic        serial_select_n_in,
    input  wire logic        serial_data_in,
    // Mode pins and status
    input  wire logic        demux_mode_in,
    input  wire logic        sdr_mode_in,
    input  wire logic        ddr_phase_90_in,
    input  wire logic        output_edge_select_in,
    input  wire logic        clock_continuous_in,
    input  wire logic        calibration_running_in,
    input  wire logic        output_clock_resync_in,
    // Converted data from the converters
    input  wire adcos_word_t conv_word_in,
    // Sample clock phase control
    output logic             sample_clock_invert_out,
    output logic [4:0]       coarse_phase_out,
    output logic [2:0]       intermediate_phase_out,
    output logic [7:0]       fine_phase_out,
    output logic [11:0]      phase_delay_ps_out,
    // Output clock and data
    output logic             data_output_clock_out,
    output logic             output_clock_valid_out,
    output adcos_word_t      data_word_out
);

    // Link domain: shift register and frame capture
    logic [4:0]   bit_cnt_reg;
    logic [19:0]  shift_reg;
    logic [19:0]  frame_reg;
    logic         frame_flag_reg;

    // Core domain
    logic [2:0]   flag_sync_reg;
    logic [1:0]   busy_sync_reg;
    logic [1:0]   resync_sync_reg;
    logic [15:0]  ext_cfg_reg;
    logic [15:0]  fine_reg;
    logic [15:0]  coarse_reg;
    adcos_state_t state_reg;
    logic [2:0]   wait_cnt_reg;
    logic         data_output_clock_reg;
    adcos_word_t  data_reg;
    adcos_word_t  ptn_word;
    logic         frame_done;
    logic         write_busy;
    logic         resync_level;
    logic         pattern_on;
    logic         cal_stop;
    logic         running;
    logic         idle_level;
    logic         release_evt;
    logic [2:0]   restart_cycles;

    // Shift in a frame; counter cleared whenever select is high
    always_ff @(posedge serial_clock_in or posedge serial_select_n_in)
    begin
        if (serial_select_n_in)
            bit_cnt_reg <= 5'h00;
        else if (bit_cnt_reg != `ADCOS_FRAME_BITS)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end

    // Data shift path
    always_ff @(posedge serial_clock_in)
    begin
        shift_reg <= {shift_reg[18:0], serial_data_in};
    end

    // Complete word captured only on the last bit
    always_ff @(posedge serial_clock_in)
    begin
        if (!serial_select_n_in && bit_cnt_reg == `ADCOS_FRAME_LAST)
            frame_reg <= {shift_reg[18:0], serial_data_in};
    end

    // Word-complete flag; select high clears it, so it never starts unknown
    always_ff @(posedge serial_clock_in or posedge serial_select_n_in)
    begin
        if (serial_select_n_in)
            frame_flag_reg <= 1'b0;
        else if (bit_cnt_reg == `ADCOS_FRAME_LAST)
            frame_flag_reg <= 1'b1;
    end

    // Flag synchroniser; third stage only for rising edge detection
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            flag_sync_reg <= 3'h0;
        else
            flag_sync_reg <= {flag_sync_reg[1:0], frame_flag_reg};
    end

    assign frame_done = flag_sync_reg[1] & ~flag_sync_reg[2];

    // Write-in-progress level and resync pin synchronisers
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            busy_sync_reg   <= 2'h0;
            resync_sync_reg <= 2'h0;
        end
        else
        begin
            busy_sync_reg   <= {busy_sync_reg[0], ~serial_select_n_in};
            resync_sync_reg <= {resync_sync_reg[0], output_clock_resync_in};
        end
    end

    assign write_busy   = busy_sync_reg[1];
    assign resync_level = resync_sync_reg[1];

    // Register writes from a completely latched word only
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ext_cfg_reg <= `ADCOS_RST_EXT_CFG;
            fine_reg    <= `ADCOS_RST_FINE;
            coarse_reg  <= `ADCOS_RST_COARSE;
        end
        else if (frame_done)
        begin
            case (frame_reg[`ADCOS_ADDR_MSB:`ADCOS_ADDR_LSB])
                `ADCOS_ADDR_EXT_CFG: ext_cfg_reg <= frame_reg[`ADCOS_DATA_MSB:`ADCOS_DATA_LSB];
                `ADCOS_ADDR_FINE:    fine_reg    <= frame_reg[`ADCOS_DATA_MSB:`ADCOS_DATA_LSB];
                `ADCOS_ADDR_COARSE:  coarse_reg  <= frame_reg[`ADCOS_DATA_MSB:`ADCOS_DATA_LSB];
                default:             ;
            endcase
        end
    end

    // Phase control outputs; registers are write-only, seen only here
    assign sample_clock_invert_out = coarse_reg[`ADCOS_INV_BIT];
    assign coarse_phase_out        = coarse_reg[`ADCOS_COARSE_MSB:`ADCOS_COARSE_LSB];
    assign intermediate_phase_out  = coarse_reg[`ADCOS_INTER_MSB:`ADCOS_INTER_LSB];
    assign fine_phase_out          = fine_reg[`ADCOS_FINE_MSB:`ADCOS_FINE_LSB];

    // Nominal coarse plus intermediate delay, at most 2092 ps
    assign phase_delay_ps_out = 12'(coarse_phase_out) * `ADCOS_COARSE_STEP_PS
                              + 12'(intermediate_phase_out) * `ADCOS_INTER_STEP_PS;

    assign pattern_on     = ext_cfg_reg[`ADCOS_PTN_BIT];
    assign cal_stop       = calibration_running_in && !clock_continuous_in;
    assign restart_cycles = (demux_mode_in && !ddr_phase_90_in) ?
                            `ADCOS_RESTART_DEMUX0 : `ADCOS_RESTART_OTHER;
    assign idle_level     = sdr_mode_in ? ~output_edge_select_in : 1'b0;

    // Resync sequencer: hold, count the restart delay, run
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_reg    <= ADCOS_ST_RUN;
            wait_cnt_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                ADCOS_ST_RUN:
                    if (resync_level)
                        state_reg <= ADCOS_ST_HOLD;
                ADCOS_ST_HOLD:
                    if (!resync_level)
                    begin
                        state_reg    <= ADCOS_ST_WAIT;
                        wait_cnt_reg <= restart_cycles - 3'h1;
                    end
                ADCOS_ST_WAIT:
                    if (resync_level)
                        state_reg <= ADCOS_ST_HOLD;
                    else if (wait_cnt_reg == 3'h0)
                        state_reg <= ADCOS_ST_RUN;
                    else
                        wait_cnt_reg <= wait_cnt_reg - 3'h1;
                default:
                    state_reg <= ADCOS_ST_HOLD;
            endcase
        end
    end

    assign release_evt = state_reg == ADCOS_ST_HOLD && !resync_level;
    assign running     = state_reg == ADCOS_ST_RUN && !resync_level
                         && !write_busy && !cal_stop;

    // Output clock: toggles while running, parked at the mode level otherwise
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            data_output_clock_reg <= 1'b0;
        else if (running)
            data_output_clock_reg <= ~data_output_clock_reg;
        else
            data_output_clock_reg <= idle_level;
    end

    assign data_output_clock_out  = data_output_clock_reg;
    assign output_clock_valid_out = running;

    // Pattern generator, restarted on every resync release
    adcos_pattern u_pattern (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .restart_in (release_evt),
        .step_in    (running),
        .demux_in   (demux_mode_in),
        .word_out   (ptn_word)
    );

    // Output data: pattern replaces converted data on all ports
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            data_reg <= '0;
        else if (running)
            data_reg <= pattern_on ? ptn_word : conv_word_in;
    end

    assign data_word_out = data_reg;

    property p_restart_delay;
        @(posedge clock_in) disable iff (rst_in)
            release_evt && !demux_mode_in ##1 !resync_level [*3]
            |=> state_reg == ADCOS_ST_RUN;
    endproperty
    a_restart_delay: assert property (p_restart_delay) else $error("restart delay wrong");

    property p_restart_not_early;
        @(posedge clock_in) disable iff (rst_in)
            release_evt |=> state_reg == ADCOS_ST_WAIT ##1 state_reg == ADCOS_ST_WAIT;
    endproperty
    a_restart_not_early: assert property (p_restart_not_early) else $error("clock restarted early");

    property p_hold_level;
        @(posedge clock_in) disable iff (rst_in)
            resync_level && $stable(idle_level) |=> data_output_clock_out == $past(idle_level);
    endproperty
    a_hold_level: assert property (p_hold_level) else $error("held clock level wrong");

    property p_cal_stop;
        @(posedge clock_in) disable iff (rst_in)
            calibration_running_in && !clock_continuous_in |-> !output_clock_valid_out;
    endproperty
    a_cal_stop: assert property (p_cal_stop) else $error("clock ran in calibration");

    property p_busy_invalid;
        @(posedge clock_in) disable iff (rst_in)
            write_busy |=> $stable(data_word_out);
    endproperty
    a_busy_invalid: assert property (p_busy_invalid) else $error("data moved during write");

    property p_coarse_write;
        @(posedge clock_in) disable iff (rst_in)
            frame_done && frame_reg[`ADCOS_ADDR_MSB:`ADCOS_ADDR_LSB] == `ADCOS_ADDR_COARSE
            |=> coarse_phase_out == $past(frame_reg[`ADCOS_COARSE_MSB:`ADCOS_COARSE_LSB]);
    endproperty
    a_coarse_write: assert property (p_coarse_write) else $error("coarse field not written");

    property p_phase_stable;
        @(posedge clock_in) disable iff (rst_in)
            !frame_done |=> $stable(fine_phase_out) && $stable(sample_clock_invert_out);
    endproperty
    a_phase_stable: assert property (p_phase_stable) else $error("phase changed without word");

    property p_max_delay;
        @(posedge clock_in) disable iff (rst_in) phase_delay_ps_out <= `ADCOS_MAX_DELAY_PS;
    endproperty
    a_max_delay: assert property (p_max_delay) else $error("phase delay too large");

    property p_pattern_out;
        @(posedge clock_in) disable iff (rst_in)
            running && pattern_on |=> data_word_out.over_range == $past(ptn_word.over_range)
            && data_word_out.q_port == $past(ptn_word.q_port);
    endproperty
    a_pattern_out: assert property (p_pattern_out) else $error("pattern not on outputs");

endmodule : adcos_output_sync
`default_nettype wire

// ==== adcos_host_model.sv ====
// Serial host model that shifts register frames into the block
`timescale 1ns/1ns
`default_nettype none

module adcos_host_model
(
    // Request from the bench
    input  wire logic        req_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] data_in,
    input  wire logic [4:0]  nbits_in,
    // Serial link
    output logic             sclk_out,
    output logic             sel_n_out,
    output logic             sdata_out,
    output logic             busy_out
);
    logic [19:0] frame;
    int          idx;

    // Link idle: clock still, select high
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        sdata_out = 1'b0;
        busy_out = 1'b0;
    end

    // One frame per request, MSB first, 30 ns link clock only inside it
    always @(posedge req_in)
    begin
        busy_out = 1'b1;
        frame = {addr_in, data_in};
        if (addr_in == 4'he)
            frame[7:0] = 8'hff;
        if (addr_in == 4'hf)
            frame[6:0] = 7'h7f;
        #7 sel_n_out = 1'b0;
        for (idx = 0; idx < nbits_in; idx++)
        begin
            sdata_out = frame[19 - idx];
            #15 sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
        end
        #15 sel_n_out = 1'b1;
        sdata_out = ~sdata_out;  // Released line shows no stale bit
        busy_out = 1'b0;
    end

endmodule : adcos_host_model
`default_nettype wire

// ==== adcos_output_sync_tb.sv ====
// Self-checking bench for the output sync and test pattern block
`timescale 1ns/1ns
`default_nettype none

module adcos_output_sync_tb
    import adcos_pkg::*;
;
    // Clock, reset and mode inputs
    logic        clock_in;
    logic        rst_in;
    logic        demux, sdr, ddr90, edge_sel, cont, cal, resync, lvl;
    adcos_word_t conv, word;
    // Serial link and host requests
    logic        sclk, sel_n, sdata, req, busy;
    logic [3:0]  addr;
    logic [15:0] data;
    logic [4:0]  nbits;
    // Design outputs
    logic        inv, data_output_clock, valid;
    logic [4:0]  coarse;
    logic [2:0]  inter;
    logic [7:0]  fine;
    logic [11:0] delay_ps;
    // Bookkeeping
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    int          gap_a, gap_b, gap_c;

    // Block under test
    adcos_output_sync dut
    (
        .clock_in               (clock_in),
        .rst_in                 (rst_in),
        .serial_clock_in        (sclk),
        .serial_select_n_in     (sel_n),
        .serial_data_in         (sdata),
        .demux_mode_in          (demux),
        .sdr_mode_in            (sdr),
        .ddr_phase_90_in        (ddr90),
        .output_edge_select_in  (edge_sel),
        .clock_continuous_in    (cont),
        .calibration_running_in (cal),
        .output_clock_resync_in (resync),
        .conv_word_in           (conv),
        .sample_clock_invert_out(inv),
        .coarse_phase_out       (coarse),
        .intermediate_phase_out (inter),
        .fine_phase_out         (fine),
        .phase_delay_ps_out     (delay_ps),
        .data_output_clock_out  (data_output_clock),
        .output_clock_valid_out (valid),
        .data_word_out          (word)
    );

    // Serial host on the far side
    adcos_host_model host
    (
        .req_in   (req),
        .addr_in  (addr),
        .data_in  (data),
        .nbits_in (nbits),
        .sclk_out (sclk),
        .sel_n_out(sel_n),
        .sdata_out(sdata),
        .busy_out (busy)
    );

    // Sample clock, 4 ns
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // Hang guard
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_total = err_total + 1;
            conclude();
        end
    end

    // Comparisons
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string nm, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_vec

    task automatic chk_word(input string nm, input adcos_word_t e, input adcos_word_t g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    // Step n clock edges, landing just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick

    // One serial frame through the host model
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d, input logic [4:0] nb);
        int n;
        addr = a;
        data = d;
        nbits = nb;
        tick(1);
        req = 1'b1;
        tick(60);
        chk_bit("valid in frame", 1'b0, valid);
        n = 0;
        while (busy === 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        req = 1'b0;
        tick(12);
    endtask : write_reg

    // Follow the pattern for two periods from its restart
    task automatic chk_pattern(input logic dmx);
        logic [9:0]  mask;
        adcos_word_t lo;
        int          len;
        mask = dmx ? 10'h00a : 10'h132;
        len = dmx ? 5 : 10;
        if (dmx)
            lo = {8'h01, 8'h02, 8'h03, 8'h04, 1'b0};
        else
            lo = {8'h01, 8'h02, 8'h01, 8'h02, 1'b0};
        // First word lands one edge after the clock restarts
        tick(1);
        for (int k = 0; k < 2 * len; k++)
        begin
            chk_word("pattern", mask[k % len] ? ~lo : lo, word);
            tick(1);
        end
    endtask : chk_pattern

    // Hold resync, check the held clock, release and time the restart
    task automatic resync_cycle(input logic hl, input logic dmx, input logic wr, output int gap);
        resync = 1'b1;
        tick(5);
        if (wr)
            write_reg(4'h9, 16'h83ff, 5'h14);
        chk_bit("held clock", hl, data_output_clock);
        chk_bit("valid held", 1'b0, valid);
        resync = 1'b0;
        gap = 0;
        while (valid !== 1'b1 && gap < 40)
        begin
            tick(1);
            gap++;
        end
        chk_pattern(dmx);
    endtask : resync_cycle

    // Verdict
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Test sequence
    initial
    begin
        rst_in = 1'b1;
        {demux, sdr, ddr90, edge_sel, cont, cal, resync} = 7'h00;
        conv = {8'h5a, 8'h3c, 8'hc3, 8'ha5, 1'b1};
        req = 1'b0;
        addr = 4'h0;
        data = 16'h0000;
        nbits = 5'h14;
        tick(2);
        rst_in = 1'b0;
        tick(3);
        chk_bit("invert", 1'b0, inv);
        chk_vec("coarse", 12'h000, 12'(coarse));
        chk_vec("inter", 12'h000, 12'(inter));
        chk_vec("fine", 12'h000, 12'(fine));
        chk_vec("delay", 12'h000, delay_ps);
        chk_bit("valid", 1'b1, valid);
        chk_word("data", conv, word);
        $display("test reset done");
        write_reg(4'hf, 16'hffff, 5'h14);
        chk_bit("invert", 1'b1, inv);
        chk_vec("coarse", 12'h01f, 12'(coarse));
        chk_vec("inter", 12'h007, 12'(inter));
        chk_vec("delay", 12'h82c, delay_ps);
        chk_bit("delay bound", 1'b1, delay_ps <= 12'h834);
        write_reg(4'hf, 16'h0480, 5'h14);
        chk_bit("invert", 1'b0, inv);
        chk_vec("delay", 12'h04c, delay_ps);
        write_reg(4'he, 16'hff00, 5'h14);
        chk_vec("fine", 12'h0ff, 12'(fine));
        write_reg(4'hf, 16'hffff, 5'h0a);
        write_reg(4'h3, 16'hffff, 5'h14);
        chk_vec("coarse", 12'h001, 12'(coarse));
        chk_vec("fine", 12'h0ff, 12'(fine));
        $display("test phase done");
        demux = 1'b1;
        resync_cycle(1'b0, 1'b1, 1'b1, gap_a);
        demux = 1'b0;
        resync_cycle(1'b0, 1'b0, 1'b0, gap_b);
        demux = 1'b1;
        ddr90 = 1'b1;
        resync_cycle(1'b0, 1'b1, 1'b0, gap_c);
        chk_vec("restart gap", 12'h001, 12'(gap_a - gap_b));
        chk_vec("restart gap", 12'(gap_b), 12'(gap_c));
        sdr = 1'b1;
        for (int e = 0; e < 2; e++)
        begin
            edge_sel = e[0];
            resync_cycle(~e[0], 1'b1, 1'b0, gap_c);
        end
        write_reg(4'h9, 16'h03ff, 5'h14);
        chk_word("data", conv, word);
        $display("test pattern done");
        cal = 1'b1;  // (resync stays low while calibration runs)
        tick(4);
        chk_bit("valid in cal", 1'b0, valid);
        lvl = data_output_clock;
        tick(1);
        chk_bit("clock stopped", lvl, data_output_clock);
        cont = 1'b1;
        tick(4);
        chk_bit("valid cont", 1'b1, valid);
        lvl = data_output_clock;
        tick(1);
        chk_bit("clock runs", ~lvl, data_output_clock);
        cal = 1'b0;
        $display("test calibration done");
        conclude();
    end

endmodule : adcos_output_sync_tb
`default_nettype wire
